// *** core/mmv_decode.sv ***
// memory map decoder and vector entry generator
`timescale 1ns/1ps
`default_nettype none

module mmv_decode #(
  parameter mmv_pkg::mmv_var_t VARIANT = mmv_pkg::MMV_VAR_LARGE_RAM
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // instruction fetch
  input  wire logic        i_if_req,
  input  wire logic [15:0] i_if_addr,
  input  wire logic [31:0] i_if_mem_data,
  output logic [2:0]       o_if_tgt,
  output logic [15:0]      o_if_idx,
  output logic             o_if_vld,
  output logic             o_if_dv,
  output logic [31:0]      o_if_data,
  // interrupt entry
  input  wire logic        i_irq_vld,
  input  wire logic [3:0]  i_irq_src,
  output logic             o_entry_vld,
  output logic [15:0]      o_entry_addr,
  // x data space
  input  wire logic        i_x_req,
  input  wire logic        i_x_we,
  input  wire logic [15:0] i_x_addr,
  input  wire logic [15:0] i_x_mem_data,
  output logic [2:0]       o_x_tgt,
  output logic [15:0]      o_x_idx,
  output logic             o_x_we,
  output logic             o_x_dv,
  output logic [15:0]      o_x_data,
  // y data space
  input  wire logic        i_y_req,
  input  wire logic        i_y_we,
  input  wire logic [15:0] i_y_addr,
  input  wire logic [15:0] i_y_mem_data,
  output logic [2:0]       o_y_tgt,
  output logic [15:0]      o_y_idx,
  output logic             o_y_we,
  output logic             o_y_dv,
  output logic [15:0]      o_y_data,
  // peripheral register selects
  output logic [8:0]       o_per_sel,
  output logic             o_per_we,
  output logic             o_per_y
);

  ////////////////////////////////////////////////////////////////////////
  // variant flags
  localparam logic LARGE = (VARIANT == mmv_pkg::MMV_VAR_LARGE_RAM);
  localparam logic EXTP  = (VARIANT == mmv_pkg::MMV_VAR_ROM_EXT);

  // all state of the block
  typedef struct packed {
    logic                booted;   // reset entry issued
    logic                ent_vld;  // entry pulse
    logic [15:0]         ent_addr; // entry address
    logic                if_vld;   // fetch decoded
    mmv_pkg::mmv_itgt_t  if_tgt;   // fetch target
    logic [15:0]         if_idx;   // offset in target
    logic                if_dv;    // fetch data valid
    logic [31:0]         if_data;  // fetch data
    logic                x_rd;     // x read decoded
    mmv_pkg::mmv_dtgt_t  x_tgt;    // x target
    logic [15:0]         x_idx;    // x offset
    logic                x_we;     // x gated write
    logic                x_dv;     // x read data valid
    logic [15:0]         x_data;   // x read data
    logic                y_rd;     // y read decoded
    mmv_pkg::mmv_dtgt_t  y_tgt;    // y target
    logic [15:0]         y_idx;    // y offset
    logic                y_we;     // y gated write
    logic                y_dv;     // y read data valid
    logic [15:0]         y_data;   // y read data
    logic [8:0]          per_sel;  // one-hot register
    logic                per_we;   // register write
    logic                per_y;    // access came from y
  } mmv_st_t;

  mmv_st_t st_r;   // registered state
  mmv_st_t st_nxt; // next state

  ////////////////////////////////////////////////////////////////////////
  // instruction address decode, 16-bit address, 32-bit words
  function automatic mmv_pkg::mmv_idec_t idec(input logic [15:0] a);
    mmv_pkg::mmv_idec_t d;
    d.tgt = mmv_pkg::MMV_I_RSVD;
    d.idx = 16'h0000;
    if (a <= mmv_pkg::I_BOOT_HI) begin
      // boot ROM in every variant
      d.tgt = mmv_pkg::MMV_I_BOOT;
      d.idx = a;
    end else if (a >= mmv_pkg::I_VEC_LO && a <= mmv_pkg::I_VEC_HI) begin
      // vector area
      d.tgt = mmv_pkg::MMV_I_VEC;
      d.idx = a - mmv_pkg::I_VEC_LO;
    end else if (LARGE && a >= mmv_pkg::I_RAM_LO &&
                 a <= mmv_pkg::I_RAM_END_L) begin
      // low instruction RAM, large part
      d.tgt = mmv_pkg::MMV_I_RAM_LO;
      d.idx = a - mmv_pkg::I_RAM_LO;
    end else if (!LARGE && a >= mmv_pkg::I_RAM_LO &&
                 a <= mmv_pkg::I_RAM_END_R) begin
      // instruction RAM, ROM parts
      d.tgt = mmv_pkg::MMV_I_RAM_LO;
      d.idx = a - mmv_pkg::I_RAM_LO;
    end else if (LARGE && a >= mmv_pkg::I_HI_LO &&
                 a <= mmv_pkg::I_RAM_HI_END) begin
      // second instruction RAM
      d.tgt = mmv_pkg::MMV_I_RAM_HI;
      d.idx = a - mmv_pkg::I_HI_LO;
    end else if (!LARGE && a >= mmv_pkg::I_HI_LO &&
                 a <= mmv_pkg::I_ROM_END) begin
      // instruction ROM, reserved above
      d.tgt = mmv_pkg::MMV_I_ROM;
      d.idx = a - mmv_pkg::I_HI_LO;
    end
    return d;
  endfunction

  // data address decode, shared by x and y
  function automatic mmv_pkg::mmv_ddec_t ddec(input logic [15:0] a);
    mmv_pkg::mmv_ddec_t d;
    d.tgt = mmv_pkg::MMV_D_RSVD;
    d.idx = 16'h0000;
    if (a <= (LARGE ? mmv_pkg::D_RAM_END_L : mmv_pkg::D_RAM_END_R)) begin
      // low data RAM
      d.tgt = mmv_pkg::MMV_D_RAM_LO;
      d.idx = a;
    end else if (LARGE && a >= mmv_pkg::D_MID_LO &&
                 a <= mmv_pkg::D_MID_HI) begin
      // middle data RAM, large part only
      d.tgt = mmv_pkg::MMV_D_RAM_MID;
      d.idx = a - mmv_pkg::D_MID_LO;
    end else if (a >= mmv_pkg::D_PER_LO && a <= mmv_pkg::D_PER_LAST) begin
      // live peripheral registers, rest of window reserved
      d.tgt = mmv_pkg::MMV_D_PER;
      d.idx = a - mmv_pkg::D_PER_LO;
    end else if (a >= mmv_pkg::D_HI_LO && a <= mmv_pkg::D_HI_END) begin
      // RAM on large part, ROM otherwise
      d.tgt = LARGE ? mmv_pkg::MMV_D_RAM_HI : mmv_pkg::MMV_D_ROM;
      d.idx = a - mmv_pkg::D_HI_LO;
    end else if (LARGE && a >= mmv_pkg::D_EXT_LO_L) begin
      // 32K external words
      d.tgt = mmv_pkg::MMV_D_EXT;
      d.idx = a - mmv_pkg::D_EXT_LO_L;
    end else if (EXTP && a >= mmv_pkg::D_EXT_LO_R) begin
      // 16K external words on the external-port ROM part
      d.tgt = mmv_pkg::MMV_D_EXT;
      d.idx = a - mmv_pkg::D_EXT_LO_R;
    end
    return d;
  endfunction

  // writable targets: not reserved, not ROM
  function automatic logic wr_ok(input mmv_pkg::mmv_dtgt_t t);
    return (t != mmv_pkg::MMV_D_RSVD) && (t != mmv_pkg::MMV_D_ROM);
  endfunction

  // one-hot peripheral register select
  function automatic logic [8:0] per_onehot(input logic [15:0] idx);
    return 9'h001 << idx[3:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    mmv_pkg::mmv_idec_t id;
    mmv_pkg::mmv_ddec_t xd;
    mmv_pkg::mmv_ddec_t yd;
    logic               x_per;
    logic               y_per;
    id     = idec(i_if_addr);
    xd     = ddec(i_x_addr);
    yd     = ddec(i_y_addr);
    x_per  = i_x_req && (xd.tgt == mmv_pkg::MMV_D_PER);
    y_per  = i_y_req && (yd.tgt == mmv_pkg::MMV_D_PER);
    st_nxt = st_r;

    // entry generation; reset entry goes first
    st_nxt.booted  = 1'b1;
    st_nxt.ent_vld = 1'b0;
    if (!st_r.booted) begin
      // first cycle after reset: reset vector
      st_nxt.ent_vld  = 1'b1;
      st_nxt.ent_addr = mmv_pkg::RESET_VEC;
    end else if (i_irq_vld && i_irq_src < mmv_pkg::NUM_SRC) begin
      // four-word slot per source
      st_nxt.ent_vld  = 1'b1;
      st_nxt.ent_addr = mmv_pkg::SRC_VEC_BASE + {10'h000, i_irq_src, 2'b00};
    end

    // instruction side: decode, then data one cycle later
    st_nxt.if_vld  = i_if_req;
    st_nxt.if_tgt  = i_if_req ? id.tgt : mmv_pkg::MMV_I_RSVD;
    st_nxt.if_idx  = i_if_req ? id.idx : 16'h0000;
    st_nxt.if_dv   = st_r.if_vld;
    // reserved fetch reads zero
    st_nxt.if_data = (st_r.if_vld && st_r.if_tgt != mmv_pkg::MMV_I_RSVD)
                     ? i_if_mem_data : 32'h0000_0000;

    // x space
    st_nxt.x_rd   = i_x_req && !i_x_we;
    st_nxt.x_tgt  = i_x_req ? xd.tgt : mmv_pkg::MMV_D_RSVD;
    st_nxt.x_idx  = i_x_req ? xd.idx : 16'h0000;
    st_nxt.x_we   = i_x_req && i_x_we && wr_ok(xd.tgt);
    st_nxt.x_dv   = st_r.x_rd;
    st_nxt.x_data = (st_r.x_rd && st_r.x_tgt != mmv_pkg::MMV_D_RSVD)
                    ? i_x_mem_data : 16'h0000;

    // y space
    st_nxt.y_rd   = i_y_req && !i_y_we;
    st_nxt.y_tgt  = i_y_req ? yd.tgt : mmv_pkg::MMV_D_RSVD;
    st_nxt.y_idx  = i_y_req ? yd.idx : 16'h0000;
    st_nxt.y_we   = i_y_req && i_y_we && wr_ok(yd.tgt);
    st_nxt.y_dv   = st_r.y_rd;
    st_nxt.y_data = (st_r.y_rd && st_r.y_tgt != mmv_pkg::MMV_D_RSVD)
                    ? i_y_mem_data : 16'h0000;

    // peripheral select: same register from either space
    if (x_per) begin
      // x served if both collide, a case software avoids
      st_nxt.per_sel = per_onehot(xd.idx);
      st_nxt.per_we  = i_x_we;
      st_nxt.per_y   = 1'b0;
    end else if (y_per) begin
      // y access to the window
      st_nxt.per_sel = per_onehot(yd.idx);
      st_nxt.per_we  = i_y_we;
      st_nxt.per_y   = 1'b1;
    end else begin
      // no peripheral access
      st_nxt.per_sel = 9'h000;
      st_nxt.per_we  = 1'b0;
      st_nxt.per_y   = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign o_if_tgt     = st_r.if_tgt;
  assign o_if_idx     = st_r.if_idx;
  assign o_if_vld     = st_r.if_vld;
  assign o_if_dv      = st_r.if_dv;
  assign o_if_data    = st_r.if_data;
  assign o_entry_vld  = st_r.ent_vld;
  assign o_entry_addr = st_r.ent_addr;
  assign o_x_tgt      = st_r.x_tgt;
  assign o_x_idx      = st_r.x_idx;
  assign o_x_we       = st_r.x_we;
  assign o_x_dv       = st_r.x_dv;
  assign o_x_data     = st_r.x_data;
  assign o_y_tgt      = st_r.y_tgt;
  assign o_y_idx      = st_r.y_idx;
  assign o_y_we       = st_r.y_we;
  assign o_y_dv       = st_r.y_dv;
  assign o_y_data     = st_r.y_data;
  assign o_per_sel    = st_r.per_sel;
  assign o_per_we     = st_r.per_we;
  assign o_per_y      = st_r.per_y;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);

  a_boot_fetch_sel: assert property (
    i_if_req && i_if_addr <= mmv_pkg::I_BOOT_HI |=>
      o_if_tgt == mmv_pkg::MMV_I_BOOT && o_if_idx == $past(i_if_addr))
    else $error("boot ROM fetch not selected");

  a_vec_fetch_sel: assert property (
    i_if_req && i_if_addr >= mmv_pkg::I_VEC_LO &&
    i_if_addr <= mmv_pkg::I_VEC_HI |=>
      o_if_tgt == mmv_pkg::MMV_I_VEC && o_if_idx[5:0] == $past(i_if_addr[5:0]))
    else $error("vector area fetch not selected");

  a_reset_entry: assert property (
    !st_r.booted |=> o_entry_vld && o_entry_addr == mmv_pkg::RESET_VEC)
    else $error("reset entry not at reset vector");

  a_entry_slot: assert property (
    o_entry_vld |-> o_entry_addr[1:0] == 2'b00 &&
      o_entry_addr >= mmv_pkg::I_VEC_LO && o_entry_addr <= mmv_pkg::I_VEC_HI)
    else $error("entry outside a vector slot");

  a_irq_entry_addr: assert property (
    st_r.booted && i_irq_vld && i_irq_src < mmv_pkg::NUM_SRC |=>
      o_entry_vld && o_entry_addr ==
      mmv_pkg::SRC_VEC_BASE + {10'h000, $past(i_irq_src), 2'b00})
    else $error("interrupt entry address wrong");

  a_iram_hi_sel: assert property (
    LARGE && i_if_req && i_if_addr >= mmv_pkg::I_HI_LO &&
    i_if_addr <= mmv_pkg::I_RAM_HI_END |=> o_if_tgt == mmv_pkg::MMV_I_RAM_HI)
    else $error("second instruction RAM not selected");

  a_irom_sel: assert property (
    !LARGE && i_if_req && i_if_addr >= mmv_pkg::I_HI_LO &&
    i_if_addr <= mmv_pkg::I_ROM_END |=> o_if_tgt == mmv_pkg::MMV_I_ROM)
    else $error("instruction ROM not selected");

  a_per_from_x: assert property (
    i_x_req && i_x_addr >= mmv_pkg::D_PER_LO &&
    i_x_addr <= mmv_pkg::D_PER_LAST |=>
      $onehot(o_per_sel) && !o_per_y &&
      o_per_sel == per_onehot($past(i_x_addr) - mmv_pkg::D_PER_LO))
    else $error("x peripheral select wrong");

  a_per_from_y: assert property (
    !i_x_req && i_y_req && i_y_addr >= mmv_pkg::D_PER_LO &&
    i_y_addr <= mmv_pkg::D_PER_LAST |=> $onehot(o_per_sel) && o_per_y)
    else $error("y peripheral select wrong");

  a_rsvd_read_zero: assert property (
    o_x_dv && $past(o_x_tgt) == mmv_pkg::MMV_D_RSVD |-> o_x_data == 16'h0000)
    else $error("reserved read not zero");

  a_no_bad_write: assert property (
    o_y_tgt == mmv_pkg::MMV_D_RSVD || o_y_tgt == mmv_pkg::MMV_D_ROM |->
      !o_y_we)
    else $error("write to reserved or ROM");

  a_ext_route: assert property (
    LARGE && i_y_req && i_y_addr >= mmv_pkg::D_EXT_LO_L |=>
      o_y_tgt == mmv_pkg::MMV_D_EXT)
    else $error("external region not routed");

  a_low_dram_sel: assert property (
    i_x_req && i_x_addr <= mmv_pkg::D_RAM_END_R |=>
      o_x_tgt == mmv_pkg::MMV_D_RAM_LO)
    else $error("low data RAM not selected");

endmodule // mmv_decode

`default_nettype wire

// *** core/mmv_pkg.sv ***
// constants and types for the memory map and vector decoder
// Function
// - instruction space: 64K words of 32 bits
// - separate X and Y data spaces, 64K x 16
// - instruction 0x0000-0x00ff selects boot ROM
// - instruction 0x200-0x23f is vector area
// - four instruction addresses per interrupt source
// - after reset, fetch starts at 0x200
// - large-RAM: 0x0240-0x0fff instruction RAM
// - large-RAM: 0x4000-0xbfff second instruction RAM
// - mask-ROM: instruction RAM ends at 0x05ff
// - mask-ROM: instruction ROM ends at 0xbeff
// - data 0x3800-0x383f is peripheral window
// - large-RAM: data RAM 0x0000-0x0fff, 0x2000-0x2fff
// - large-RAM: data RAM 0x4000-0x7fff
// - large-RAM: data 0x8000 upward is external
// - mask-ROM: data RAM 0x0000-0x0bff
// - mask-ROM: read-only data ROM from 0x4000
// - external-port ROM variant: 0xc000 up external
// - peripheral registers 0x3800-0x3808, rest reserved
// - peripheral reached alike from X or Y
package mmv_pkg;

  // product variants
  typedef enum logic [1:0] {
    MMV_VAR_LARGE_RAM = 2'b00,
    MMV_VAR_ROM_NOEXT = 2'b01,
    MMV_VAR_ROM_EXT   = 2'b10
  } mmv_var_t;

  // instruction-side targets
  typedef enum logic [2:0] {
    MMV_I_RSVD   = 3'b000,
    MMV_I_BOOT   = 3'b001,
    MMV_I_VEC    = 3'b010,
    MMV_I_RAM_LO = 3'b011,
    MMV_I_RAM_HI = 3'b100,
    MMV_I_ROM    = 3'b101
  } mmv_itgt_t;

  // data-side targets
  typedef enum logic [2:0] {
    MMV_D_RSVD    = 3'b000,
    MMV_D_RAM_LO  = 3'b001,
    MMV_D_RAM_MID = 3'b010,
    MMV_D_RAM_HI  = 3'b011,
    MMV_D_ROM     = 3'b100,
    MMV_D_PER     = 3'b101,
    MMV_D_EXT     = 3'b110
  } mmv_dtgt_t;

  // widths
  localparam int AW  = 16;
  localparam int IW  = 32;
  localparam int DW  = 16;
  localparam int NPR = 9;

  // instruction map
  localparam logic [15:0] I_BOOT_HI    = 16'h00ff;
  localparam logic [15:0] I_VEC_LO     = 16'h0200;
  localparam logic [15:0] I_VEC_HI     = 16'h023f;
  localparam logic [15:0] I_RAM_LO     = 16'h0240;
  localparam logic [15:0] I_RAM_END_L  = 16'h0fff;
  localparam logic [15:0] I_RAM_END_R  = 16'h05ff;
  localparam logic [15:0] I_HI_LO      = 16'h4000;
  localparam logic [15:0] I_RAM_HI_END = 16'hbfff;
  localparam logic [15:0] I_ROM_END    = 16'hbeff;

  // vectors
  localparam logic [15:0] RESET_VEC    = 16'h0200;
  localparam logic [15:0] SRC_VEC_BASE = 16'h0210;
  localparam logic [3:0]  NUM_SRC      = 4'ha;

  // data map
  localparam logic [15:0] D_RAM_END_L  = 16'h0fff;
  localparam logic [15:0] D_RAM_END_R  = 16'h0bff;
  localparam logic [15:0] D_MID_LO     = 16'h2000;
  localparam logic [15:0] D_MID_HI     = 16'h2fff;
  localparam logic [15:0] D_PER_LO     = 16'h3800;
  localparam logic [15:0] D_PER_LAST   = 16'h3808;
  localparam logic [15:0] D_HI_LO      = 16'h4000;
  localparam logic [15:0] D_HI_END     = 16'h7fff;
  localparam logic [15:0] D_EXT_LO_L   = 16'h8000;
  localparam logic [15:0] D_EXT_LO_R   = 16'hc000;

  // decode results
  typedef struct packed {
    mmv_itgt_t   tgt;
    logic [15:0] idx;
  } mmv_idec_t;

  typedef struct packed {
    mmv_dtgt_t   tgt;
    logic [15:0] idx;
  } mmv_ddec_t;

endpackage

// *** verification/mmv_core_model.sv ***
// behavioural model of the memories behind the decoder
`timescale 1ns/1ps
`default_nettype none

module mmv_core_model (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // decoded selects from the decoder
  input  wire logic [2:0]  i_if_tgt,
  input  wire logic [15:0] i_if_idx,
  input  wire logic [2:0]  i_x_tgt,
  input  wire logic [15:0] i_x_idx,
  input  wire logic [2:0]  i_y_tgt,
  input  wire logic [15:0] i_y_idx,
  // read data back to the decoder
  output logic [31:0]      o_if_mem_data,
  output logic [15:0]      o_x_mem_data,
  output logic [15:0]      o_y_mem_data
);
  logic [15:0] churn_r;  // changes every cycle, stands for unknown data

  ////////////////////////////////////////////////////////////////////////////
  // free-running churn, so a stale or reserved read cannot match by luck
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) churn_r <= 16'h9e37;
    else churn_r <= {churn_r[14:0], churn_r[15] ^ churn_r[13]} + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // memories answer with a word derived from the offset; the vector area
  // is always loaded, reset slot and trap slots included
  // reserved places hold nothing defined, only churn
  always_comb begin
    o_if_mem_data = (i_if_tgt != 3'h0) ? {~i_if_idx, i_if_idx}
                                       : {churn_r, ~churn_r};
    o_x_mem_data  = (i_x_tgt != 3'h0) ? (i_x_idx ^ 16'h3c3c) : churn_r;
    o_y_mem_data  = (i_y_tgt != 3'h0) ? (i_y_idx ^ 16'h3c3c) : ~churn_r;
  end
endmodule // mmv_core_model

`default_nettype wire

// *** verification/tb.sv ***
// self-checking testbench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk = 1'b0;  // starts low, so no false edge at time zero
  logic        rst = 1'b1;  // held from the very first instant
  logic        ir, xr, xw, yr, yw, irq;
  logic [15:0] ia, xa, ya;
  logic [3:0]  src;
  wire  [31:0] imd;
  wire  [15:0] xmd, ymd, if_idx, x_idx, y_idx;
  wire  [2:0]  if_tgt, x_tgt, y_tgt;
  wire         if_vld, if_dv, ev, xwe, xdv, ywe, ydv, pwe, py;
  wire  [31:0] if_data;
  wire  [15:0] ea_o, xd, yd;
  wire  [8:0]  psel;
  // decode outputs of the two mask-ROM variants, indexed by variant code
  wire  [2:1][2:0]  rt_i, rt_x, rt_y;
  wire  [2:1][15:0] ri_i, ri_x;
  wire  [2:1]       rwe_y;
  integer      miscompares, tests_run, seed, k;
  logic [15:0] corner [30];
  // one- and two-cycle-old copies of the requests
  logic        ir1, ir2, xr1, xr2, xw1, xw2, yr1, yr2, yw1, yw2, ev1, rst_d;
  logic [15:0] ia1, ia2, xa1, xa2, ya1, ya2, ea;
  logic [18:0] e;

  mmv_decode u_dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_if_req(ir), .i_if_addr(ia),
    .i_if_mem_data(imd), .o_if_tgt(if_tgt), .o_if_idx(if_idx),
    .o_if_vld(if_vld), .o_if_dv(if_dv), .o_if_data(if_data),
    .i_irq_vld(irq), .i_irq_src(src), .o_entry_vld(ev), .o_entry_addr(ea_o),
    .i_x_req(xr), .i_x_we(xw), .i_x_addr(xa), .i_x_mem_data(xmd),
    .o_x_tgt(x_tgt), .o_x_idx(x_idx), .o_x_we(xwe), .o_x_dv(xdv),
    .o_x_data(xd), .i_y_req(yr), .i_y_we(yw), .i_y_addr(ya),
    .i_y_mem_data(ymd), .o_y_tgt(y_tgt), .o_y_idx(y_idx), .o_y_we(ywe),
    .o_y_dv(ydv), .o_y_data(yd), .o_per_sel(psel), .o_per_we(pwe),
    .o_per_y(py));

  mmv_core_model u_mem (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_if_tgt(if_tgt), .i_if_idx(if_idx),
    .i_x_tgt(x_tgt), .i_x_idx(x_idx), .i_y_tgt(y_tgt), .i_y_idx(y_idx),
    .o_if_mem_data(imd), .o_x_mem_data(xmd), .o_y_mem_data(ymd));

  // mask-ROM variants see the same traffic; only their decode is checked
  for (genvar g = 1; g < 3; g++) begin : g_rom
    mmv_decode #(.VARIANT(mmv_pkg::mmv_var_t'(g))) u_dut (
      .i_clk_sys(clk), .i_sys_rst(rst), .i_if_req(ir), .i_if_addr(ia),
      .i_if_mem_data(imd), .o_if_tgt(rt_i[g]), .o_if_idx(ri_i[g]),
      .o_if_vld(), .o_if_dv(), .o_if_data(), .i_irq_vld(irq),
      .i_irq_src(src), .o_entry_vld(), .o_entry_addr(), .i_x_req(xr),
      .i_x_we(xw), .i_x_addr(xa), .i_x_mem_data(xmd), .o_x_tgt(rt_x[g]),
      .o_x_idx(ri_x[g]), .o_x_we(), .o_x_dv(), .o_x_data(), .i_y_req(yr),
      .i_y_we(yw), .i_y_addr(ya), .i_y_mem_data(ymd), .o_y_tgt(rt_y[g]),
      .o_y_idx(), .o_y_we(rwe_y[g]), .o_y_dv(), .o_y_data(),
      .o_per_sel(), .o_per_we(), .o_per_y());
  end

  ////////////////////////////////////////////////////////////////////////////
  // expected instruction target and offset; v 0 large RAM, else mask ROM
  function automatic logic [18:0] itgt(input logic [15:0] a, input int v);
    if (a <= 16'h00ff) return {3'h1, a};
    if (a >= 16'h0200 && a <= 16'h023f) return {3'h2, a - 16'h0200};
    if (v == 0 && a >= 16'h0240 && a <= 16'h0fff) return {3'h3, a - 16'h0240};
    if (v == 0 && a >= 16'h4000 && a <= 16'hbfff) return {3'h4, a - 16'h4000};
    if (v != 0 && a >= 16'h0240 && a <= 16'h05ff) return {3'h3, a - 16'h0240};
    if (v != 0 && a >= 16'h4000 && a <= 16'hbeff) return {3'h5, a - 16'h4000};
    return 19'h0;
  endfunction

  // expected data target and offset; v 2 has the external data port
  function automatic logic [18:0] dtgt(input logic [15:0] a, input int v);
    if (a <= ((v == 0) ? 16'h0fff : 16'h0bff)) return {3'h1, a};
    if (v == 0 && a >= 16'h2000 && a <= 16'h2fff) return {3'h2, a - 16'h2000};
    if (a >= 16'h3800 && a <= 16'h3808) return {3'h5, a - 16'h3800};
    if (a >= 16'h4000 && a <= 16'h7fff)
      return {(v == 0) ? 3'h3 : 3'h4, a - 16'h4000};
    if (v == 0 && a >= 16'h8000) return {3'h6, a - 16'h8000};
    if (v == 2 && a >= 16'hc000) return {3'h6, a - 16'hc000};
    return 19'h0;
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one data space: decode a cycle back, read data two cycles back
  task automatic chk_d(input logic r1, w1, r2, w2, input logic [15:0] a1,
                       a2, input logic [2:0] t, input logic [15:0] ix, d,
                       input logic we, dv);
    logic [18:0] x;
    x = dtgt(a1, 0);
    if (r1) chk({13'h0, t, ix}, {13'h0, x});
    chk(we, r1 & w1 & (x[18:16] != 3'h0));
    chk(dv, r2 & ~w2);
    x = dtgt(a2, 0);
    if (dv === 1'b1)
      chk(d, (x[18:16] == 3'h0) ? 16'h0 : x[15:0] ^ 16'h3c3c);
  endtask

  // verdict and end of run
  task automatic conclude;
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // random address, often a map boundary
  function automatic logic [15:0] pick;
    if ($random(seed) & 1) return corner[$unsigned($random(seed)) % 30];
    return 16'($random(seed));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // request history and expected entry address
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {ir1, ir2, xr1, xr2, xw1, xw2, yr1, yr2, yw1, yw2, ev1} <= '0;
      {ia1, ia2, xa1, xa2, ya1, ya2, ea} <= '0;
      rst_d <= 1'b1;
    end else begin
      rst_d <= 1'b0;
      {ir1, ia1, ir2, ia2} <= {ir, ia, ir1, ia1};
      {xr1, xw1, xa1, xr2, xw2, xa2} <= {xr, xw, xa, xr1, xw1, xa1};
      {yr1, yw1, ya1, yr2, yw2, ya2} <= {yr, yw, ya, yr1, yw1, ya1};
      ev1 <= rst_d | (irq & (src < 4'ha));
      if (rst_d) ea <= 16'h0200;
      else if (irq && src < 4'ha) ea <= 16'h0210 + {10'h0, src, 2'b00};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output checks, half a cycle after each edge
  always @(negedge clk) begin
    chk(if_vld, ir1);
    e = itgt(ia1, 0);
    if (ir1) chk({13'h0, if_tgt, if_idx}, {13'h0, e});
    chk(if_dv, ir2);
    e = itgt(ia2, 0);
    if (ir2)
      chk(if_data, (e[18:16] == 3'h0) ? 32'h0 : {~e[15:0], e[15:0]});
    // mask-ROM variants, fed the same traffic
    for (int g = 1; g < 3; g++) begin
      e = itgt(ia1, g);
      if (ir1) chk({13'h0, rt_i[g], ri_i[g]}, {13'h0, e});
      e = dtgt(xa1, g);
      if (xr1) chk({13'h0, rt_x[g], ri_x[g]}, {13'h0, e});
      e = dtgt(ya1, g);
      if (yr1) chk(rt_y[g], e[18:16]);
      chk(rwe_y[g], yr1 & yw1 & (e[18:16] != 3'h0) &
                    (e[18:16] != 3'h4));
    end
    chk(ev, ev1);
    chk(ea_o, ea);
    chk_d(xr1, xw1, xr2, xw2, xa1, xa2, x_tgt, x_idx, xd, xwe, xdv);
    chk_d(yr1, yw1, yr2, yw2, ya1, ya2, y_tgt, y_idx, yd, ywe, ydv);
    if (xr1 && dtgt(xa1, 0) >> 16 == 19'h5)
      chk({pwe, py, psel}, {xw1, 1'b0, 9'h1 << (xa1 - 16'h3800)});
    else if (yr1 && dtgt(ya1, 0) >> 16 == 19'h5)
      chk({pwe, py, psel}, {yw1, 1'b1, 9'h1 << (ya1 - 16'h3800)});
    else chk({pwe, py, psel}, 11'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    miscompares = 0;
    tests_run = 0;
    seed = 32'h3718d2ac;
    corner = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200, 16'h023f, 16'h0240,
               16'h0fff, 16'h1000, 16'h3fff, 16'h4000, 16'hbfff, 16'hc000,
               16'h37ff, 16'h3800, 16'h3808, 16'h3809, 16'h383f, 16'h3840,
               16'h2000, 16'h2fff, 16'h3000, 16'h7fff, 16'h8000, 16'hffff,
               16'h05ff, 16'h0600, 16'h0bff, 16'h0c00, 16'hbeff, 16'hbf00};
    {ir, xr, xw, yr, yw, irq, ia, xa, ya, src} <= '0;
    rst = 1'b1;
    for (k = 0; k < 2; k++) begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      irq <= 1'b1;                       // dropped behind the reset entry
      src <= 4'h0;
      // every source code back to back, valid and invalid ones
      for (int s = 0; s < 16; s++) begin
        @(posedge clk);
        src <= s[3:0];
      end
      @(posedge clk);
      irq <= 1'b0;
      // random traffic on all ports
      repeat (1500) begin
        @(posedge clk);
        ir <= 1'($random(seed));
        ia <= pick();
        xr <= 1'($random(seed));
        xw <= 1'($random(seed));
        xa <= pick();
        yr <= 1'($random(seed));
        yw <= 1'($random(seed));
        ya <= pick();
        irq <= (($random(seed) & 3) == 0);
        src <= 4'($random(seed));
      end
      @(posedge clk);
      rst <= 1'b1;                       // reset again in mid-traffic, once at the end of each pass
    end
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule // tb

`default_nettype wire
